// ==== rtl/ipm_phase_manager.sv ====
// Interleaved two-phase clock, drive gating and ready logic
`timescale 1ns/10ps
`include "ipm_regs.svh"
module ipm_phase_manager #(
  parameter int WDOG_CYC = `IPM_WDOG_CYC
) (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // Analog comparator inputs (asynchronous)
  input wire logic ramp_above_high_i,
  input wire logic ramp_below_low_i,
  input wire logic ovp_i,
  input wire logic inrush_i,
  input wire logic demag_one_i,
  input wire logic demag_two_i,
  input wire logic ea_charging_i,
  input wire logic circuit_on_i,
  input wire logic fault_i,
  // PWM reset from on-time comparators (asynchronous)
  input wire logic ton_end_one_i,
  input wire logic ton_end_two_i,
  // Interrupt register port
  input wire logic [1:0] reg_addr_i,
  input wire logic [`IPM_INT_W-1:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [`IPM_INT_W-1:0] reg_rdata_o,
  output logic irq_o,
  // Drive, clock and status outputs
  output logic drive_one_o,
  output logic drive_two_o,
  output logic phase_one_clock_o,
  output logic phase_two_clock_o,
  output logic sync_o,
  output logic discharge_hold_o,
  output logic ovp_to_ton_o,
  output logic startup_flag_o,
  output logic stage_ready_out_o,
  output ipm_pkg::ipm_phase_t phase_sel_o
);
  import ipm_pkg::*;

  // ------------------------------------------------------------
  // Input synchronisers
  // ------------------------------------------------------------
  localparam int NIN = 11;
  logic [NIN-1:0] raw_in;
  logic [NIN-1:0] meta_reg;
  logic [NIN-1:0] sync_reg;
  assign raw_in = {ton_end_two_i, ton_end_one_i, fault_i, circuit_on_i, ea_charging_i,
                   demag_two_i, demag_one_i, inrush_i, ovp_i, ramp_below_low_i, ramp_above_high_i};
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else begin
      meta_reg <= raw_in;
      sync_reg <= meta_reg;
    end
  end
  logic hi_s, lo_s, ovp_s, inr_s, dm1_s, dm2_s, eac_s, on_s, flt_s, te1_s, te2_s;
  assign {te2_s, te1_s, flt_s, on_s, eac_s, dm2_s, dm1_s, inr_s, ovp_s, lo_s, hi_s} = sync_reg;

  function automatic logic rise(input logic now, input logic prev);
    rise = now & ~prev;
  endfunction

  // ------------------------------------------------------------
  // Oscillator sync and phase selection
  // ------------------------------------------------------------
  logic sync_reg_q, sync_next;
  logic drv1_reg, drv2_reg;
  logic drv1_prev, drv2_prev;
  logic sync_fall;
  logic sel_drv_on;
  ipm_phase_t phase_reg;
  assign sel_drv_on = (phase_reg == IPM_PH_ONE) ? drv1_reg : drv2_reg;

  // [R09] [R13] Sync from ramp thresholds
  always_comb begin
    sync_next = sync_reg_q;
    if (!sync_reg_q && hi_s) begin
      sync_next = 1'b1;
    end else if (sync_reg_q && lo_s) begin
      sync_next = 1'b0;
    end
  end
  // Discharge is held past the low threshold until the selected driver is on
  logic hold_reg;
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      sync_reg_q <= 1'b0;
      hold_reg <= 1'b0;
    end else begin
      sync_reg_q <= sync_next;
      // [R13] Extend discharge
      hold_reg <= (sync_reg_q | hold_reg) & lo_s & ~sel_drv_on & ~hi_s;
    end
  end
  assign sync_fall = sync_reg_q & ~sync_next;

  // [R10] [R18] Alternate phase on each sync rising edge
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      phase_reg <= IPM_PH_TWO;
    end else if (rise(sync_next, sync_reg_q)) begin
      case (phase_reg)
        IPM_PH_ONE: phase_reg <= IPM_PH_TWO;
        IPM_PH_TWO: phase_reg <= IPM_PH_ONE;
        default: phase_reg <= IPM_PH_ONE;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Clock generator latches
  // ------------------------------------------------------------
  logic arm1_reg, arm2_reg, phase_one_clock_reg, phase_two_clock_reg;
  logic drv1_rise, drv2_rise;
  assign drv1_rise = rise(drv1_reg, drv1_prev);
  assign drv2_rise = rise(drv2_reg, drv2_prev);
  // [R11] [R12] [R18] Armed by sync, clock out on sync fall, cleared by driver rise
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      arm1_reg <= 1'b0;
      arm2_reg <= 1'b0;
      phase_one_clock_reg <= 1'b0;
      phase_two_clock_reg <= 1'b0;
    end else begin
      if (sync_reg_q && phase_reg == IPM_PH_ONE) begin
        arm1_reg <= 1'b1;
      end else if (drv1_rise) begin
        arm1_reg <= 1'b0;
      end
      if (sync_reg_q && phase_reg == IPM_PH_TWO) begin
        arm2_reg <= 1'b1;
      end else if (drv2_rise) begin
        arm2_reg <= 1'b0;
      end
      if (drv1_rise) begin
        phase_one_clock_reg <= 1'b0;
      end else if (sync_fall && arm1_reg) begin
        phase_one_clock_reg <= 1'b1;
      end
      if (drv2_rise) begin
        phase_two_clock_reg <= 1'b0;
      end else if (sync_fall && arm2_reg) begin
        phase_two_clock_reg <= 1'b1;
      end
    end
  end

  // ------------------------------------------------------------
  // Demagnetisation latches and watchdogs
  // ------------------------------------------------------------
  logic dml1_reg, dml2_reg;
  logic [`IPM_WDOG_W-1:0] wd1_reg, wd2_reg;
  logic wd1_hit, wd2_hit;
  assign wd1_hit = (wd1_reg >= WDOG_CYC[`IPM_WDOG_W-1:0] - 16'h0001);
  assign wd2_hit = (wd2_reg >= WDOG_CYC[`IPM_WDOG_W-1:0] - 16'h0001);
  // [R16] Watchdog counts while the driver is low
  always_ff @(posedge clk_sys_i) begin
    if (rst_i || drv1_reg) begin
      wd1_reg <= '0;
    end else if (!wd1_hit) begin
      wd1_reg <= wd1_reg + 16'h0001;
    end
  end
  always_ff @(posedge clk_sys_i) begin
    if (rst_i || drv2_reg) begin
      wd2_reg <= '0;
    end else if (!wd2_hit) begin
      wd2_reg <= wd2_reg + 16'h0001;
    end
  end
  // [R15] [R16] Set by winding or watchdog, cleared at next drive pulse
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      dml1_reg <= 1'b0;
      dml2_reg <= 1'b0;
    end else begin
      if (drv1_rise) begin
        dml1_reg <= 1'b0;
      end else if (dm1_s || wd1_hit) begin
        dml1_reg <= 1'b1;
      end
      if (drv2_rise) begin
        dml2_reg <= 1'b0;
      end else if (dm2_s || wd2_hit) begin
        dml2_reg <= 1'b1;
      end
    end
  end

  // ------------------------------------------------------------
  // PWM latches and drive gating
  // ------------------------------------------------------------
  logic pwm_block;
  // [R01] [R17] Over-voltage, inrush, off state or fault block switching
  assign pwm_block = ovp_s | inr_s | ~on_s | flt_s;
  // [R14] [R08] A clock only sets the latch once the core is reset
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      drv1_reg <= 1'b0;
      drv2_reg <= 1'b0;
      drv1_prev <= 1'b0;
      drv2_prev <= 1'b0;
    end else begin
      drv1_prev <= drv1_reg;
      drv2_prev <= drv2_reg;
      // [R01] Drives held off during over-voltage
      if (pwm_block || te1_s) begin
        drv1_reg <= 1'b0;
      end else if (phase_one_clock_reg && dml1_reg && !dm1_s) begin
        drv1_reg <= 1'b1;
      end
      if (pwm_block || te2_s) begin
        drv2_reg <= 1'b0;
      end else if (phase_two_clock_reg && dml2_reg && !dm2_s) begin
        drv2_reg <= 1'b1;
      end
    end
  end

  // ------------------------------------------------------------
  // Start-up latch and ready output
  // ------------------------------------------------------------
  logic startup_flag_reg, ready_reg, ovp_reg, ready_prev_reg;
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      startup_flag_reg <= 1'b1;
    end else if (!on_s) begin
      // [R04] Set during the off phase
      startup_flag_reg <= 1'b1;
    end else if (!eac_s) begin
      // [R05] Cleared when the error amplifier stops charging
      startup_flag_reg <= 1'b0;
    end
  end
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      ready_reg <= 1'b0;
      ovp_reg <= 1'b0;
      ready_prev_reg <= 1'b0;
    end else begin
      ready_prev_reg <= ready_reg;
      // [R03] [R06] Ready only when on, fault free and start-up over
      ready_reg <= on_s & ~flt_s & ~startup_flag_reg;
      // [R02] Over-voltage reported to on-time processing
      ovp_reg <= ovp_s;
    end
  end

  // ------------------------------------------------------------
  // Interrupt status and mask
  // ------------------------------------------------------------
  logic [`IPM_INT_W-1:0] stat_reg, mask_reg, ev;
  logic [`IPM_INT_W-1:0] rdata_reg;
  logic irq_reg;
  always_comb begin
    ev = '0;
    ev[`IPM_INT_SYNC] = sync_fall;
    ev[`IPM_INT_OVP] = rise(ovp_s, ovp_reg);
    ev[`IPM_INT_FAULT] = flt_s;
    // Edge of the registered ready, so a steady ready raises one event only
    ev[`IPM_INT_READY] = rise(ready_reg, ready_prev_reg);
  end
  // Set wins over a simultaneous write-one clear
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      stat_reg <= '0;
      mask_reg <= '0;
    end else begin
      if (reg_wr_i && reg_addr_i == `IPM_ADDR_STAT) begin
        stat_reg <= (stat_reg & ~reg_wdata_i) | ev;
      end else begin
        stat_reg <= stat_reg | ev;
      end
      if (reg_wr_i && reg_addr_i == `IPM_ADDR_MASK) begin
        mask_reg <= reg_wdata_i;
      end
    end
  end
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      rdata_reg <= '0;
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= |(stat_reg & mask_reg);
      if (reg_rd_i) begin
        case (reg_addr_i)
          `IPM_ADDR_STAT: rdata_reg <= stat_reg;
          `IPM_ADDR_MASK: rdata_reg <= mask_reg;
          default: rdata_reg <= '0;
        endcase
      end else begin
        rdata_reg <= '0;
      end
    end
  end

  assign reg_rdata_o = rdata_reg;
  assign irq_o = irq_reg;
  assign drive_one_o = drv1_reg;
  assign drive_two_o = drv2_reg;
  assign phase_one_clock_o = phase_one_clock_reg;
  assign phase_two_clock_o = phase_two_clock_reg;
  assign sync_o = sync_reg_q;
  assign discharge_hold_o = hold_reg;
  assign ovp_to_ton_o = ovp_reg;
  assign startup_flag_o = startup_flag_reg;
  assign stage_ready_out_o = ready_reg;
  assign phase_sel_o = phase_reg;

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  a_ovp_drive_off: assert property (@(posedge clk_sys_i) disable iff (rst_i) // [R01]
    ovp_s |=> !drv1_reg && !drv2_reg) else $error("drive on during over-voltage");
  a_ovp_flag: assert property (@(posedge clk_sys_i) disable iff (rst_i) // [R02]
    ovp_s |=> ovp_to_ton_o) else $error("over-voltage not reported");
  a_ready_fault: assert property (@(posedge clk_sys_i) disable iff (rst_i) // [R06]
    (flt_s || !on_s) |=> !stage_ready_out_o) else $error("ready high in fault");
  a_ready_startup_flag: assert property (@(posedge clk_sys_i) disable iff (rst_i) // [R03]
    stage_ready_out_o |-> $past(!startup_flag_reg)) else $error("ready during start-up");
  a_startup_flag_off: assert property (@(posedge clk_sys_i) disable iff (rst_i) // [R04]
    !on_s |=> startup_flag_reg) else $error("start-up latch not set when off");
  a_startup_flag_clr: assert property (@(posedge clk_sys_i) disable iff (rst_i) // [R05]
    (on_s && !eac_s) |=> !startup_flag_reg) else $error("start-up latch not cleared");
  a_phase_alt: assert property (@(posedge clk_sys_i) disable iff (rst_i) // [R10]
    rise(sync_next, sync_reg_q) |=> phase_reg != $past(phase_reg)) else $error("phase did not toggle");
  a_clk_fall: assert property (@(posedge clk_sys_i) disable iff (rst_i) // [R11]
    $rose(phase_one_clock_reg) |-> $past(sync_fall)) else $error("clock not on sync fall");
  a_clk_hold: assert property (@(posedge clk_sys_i) disable iff (rst_i) // [R12]
    $fell(phase_one_clock_reg) |-> $past(drv1_rise)) else $error("clock dropped without driver");
  a_zcd_gate: assert property (@(posedge clk_sys_i) disable iff (rst_i) // [R14]
    $rose(drv1_reg) |-> $past(dml1_reg && phase_one_clock_reg)) else $error("drive without demag");
  a_inrush_blk: assert property (@(posedge clk_sys_i) disable iff (rst_i) // [R17]
    inr_s |=> !$rose(drv1_reg) && !$rose(drv2_reg)) else $error("drive rose during inrush");
  a_demag_clr: assert property (@(posedge clk_sys_i) disable iff (rst_i) // [R15]
    drv1_rise |=> !dml1_reg) else $error("demag latch not cleared");
  a_wdog_set: assert property (@(posedge clk_sys_i) disable iff (rst_i) // [R16]
    wd1_hit && !drv1_rise |=> dml1_reg) else $error("watchdog did not set demag latch");
  c_ph_one: cover property (@(posedge clk_sys_i) $rose(drv1_reg));
  c_ph_two: cover property (@(posedge clk_sys_i) $rose(drv2_reg));
  c_ready: cover property (@(posedge clk_sys_i) $rose(stage_ready_out_o));
  c_hold: cover property (@(posedge clk_sys_i) $rose(hold_reg));
endmodule

// ==== rtl/ipm_regs.svh ====
// Constants and rule overview for the interleaved phase manager
// Overview of operation
// [R01] Over-voltage input holds both gate drives off.
// [R02] Over-voltage flag goes to on-time logic; idle time not counted as dead time.
// [R03] Ready output high only in normal regulated operation, low otherwise.
// [R04] Start-up latch is set during every off phase.
// [R05] Start-up latch clears when error amplifier stops charging; ready may rise.
// [R06] Ready forced low when off or any fault present.
// [R07] Downstream converter should run only while ready is high.
// [R08] Each branch switches at most at half the oscillator rate.
// [R09] Sync follows ramp comparator: high above upper, low below lower threshold.
// [R10] Divide-by-two selector alternates phase one and two on sync pulses.
// [R11] Sync sets selected clock latch; clock issued on falling edge of sync.
// [R12] Phase clock held until its driver rises; driver rising edge clears it.
// [R13] Discharge extended until selected driver turns on.
// [R14] Phase clock may not set PWM latch until zero current is sensed.
// [R15] Demag latch set by winding comparator, cleared at next driver pulse.
// [R16] Driver low beyond 200 us sets demag latch by watchdog.
// [R17] Inrush comparator high blocks both PWM latches from setting.
// [R18] Reset starts at phase one, clock latches clear, drivers low; code resets the selector to phase two, first sync picks one.
`ifndef IPM_REGS_SVH
`define IPM_REGS_SVH
// Watchdog time in ns and its cycle count at a 4 ns clock
`define IPM_WDOG_NS 200000
`define IPM_CLK_NS 4
`define IPM_WDOG_CYC (`IPM_WDOG_NS / `IPM_CLK_NS)
`define IPM_WDOG_W 16
`define IPM_INT_W 4
`define IPM_INT_SYNC 0
`define IPM_INT_OVP 1
`define IPM_INT_FAULT 2
`define IPM_INT_READY 3
// Register offsets on the interrupt port
`define IPM_ADDR_STAT 2'h0
`define IPM_ADDR_MASK 2'h1
`endif

// ==== rtl/ipm_pkg.sv ====
// Types for the interleaved phase manager
package ipm_pkg;
  typedef enum logic [1:0] {
    IPM_PH_ONE = 2'b01,
    IPM_PH_TWO = 2'b10
  } ipm_phase_t;
endpackage

// ==== bench/ipm_gate_model.sv ====
// Gate driver and downstream converter model for the phase manager bench
`timescale 1ns/10ps
module ipm_gate_model #(
  parameter int TON = 6,
  parameter int DEMAG = 5
) (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // Drives and ready from the block, core hold from the bench
  input wire logic [1:0] drive_i,
  input wire logic stage_ready_i,
  input wire logic hold_demag_i,
  // Winding and on-time feedback, converter run
  output logic [1:0] demag_o,
  output logic [1:0] ton_end_o,
  output logic conv_run_o
);
  int ton_cnt [2];
  int dem_cnt [2];
  assign conv_run_o = stage_ready_i;
  always_ff @(posedge clk_sys_i) begin
    for (int p = 0; p < 2; p++) begin
      if (rst_i || !drive_i[p]) begin
        ton_cnt[p] <= 0;
      end else begin
        ton_cnt[p] <= ton_cnt[p] + 1;
      end
      if (rst_i) begin
        dem_cnt[p] <= 0;
      end else if (drive_i[p]) begin
        dem_cnt[p] <= DEMAG;
      end else if (dem_cnt[p] > 0) begin
        dem_cnt[p] <= dem_cnt[p] - 1;
      end
    end
  end
  // Winding rings high after turn-off; a stuck core keeps it high
  always_comb begin
    for (int p = 0; p < 2; p++) begin
      demag_o[p] = !drive_i[p] && (dem_cnt[p] > 0 || hold_demag_i);
      ton_end_o[p] = ton_cnt[p] >= TON;
    end
  end
endmodule

// ==== bench/tb.sv ====
// Self-checking bench for the interleaved phase manager
`timescale 1ns/10ps
`include "ipm_regs.svh"
module tb;
  import ipm_pkg::*;
  // ------------------------------------------------------------
  // Stimulus and observed signals
  // ------------------------------------------------------------
  logic clk_sys_i = 1'b0;
  logic rst_i = 1'b1;
  logic ramp_hi = 1'b0, ramp_lo = 1'b0, ovp = 1'b0, inrush = 1'b0;
  logic ea_chg = 1'b1, on = 1'b0, fault = 1'b0, hold_dem = 1'b0;
  logic [1:0] addr = 2'h0;
  logic [`IPM_INT_W-1:0] wdata = 4'h0;
  logic wr = 1'b0, rd = 1'b0;
  logic [`IPM_INT_W-1:0] rdata;
  logic irq, drv1, drv2, phase_one_clock, phase_two_clock, sync, dhold, ovp_ton, startup_flag, ready, conv_run;
  logic [1:0] demag, ton_end;
  ipm_phase_t sel;
  int num_errors = 0;
  int n_checks = 0;
  always #2 clk_sys_i = ~clk_sys_i;
  // Short watchdog keeps the first start quick
  ipm_phase_manager #(.WDOG_CYC(20)) DUT (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
    .ramp_above_high_i(ramp_hi), .ramp_below_low_i(ramp_lo), .ovp_i(ovp), .inrush_i(inrush),
    .demag_one_i(demag[0]), .demag_two_i(demag[1]), .ea_charging_i(ea_chg), .circuit_on_i(on),
    .fault_i(fault), .ton_end_one_i(ton_end[0]), .ton_end_two_i(ton_end[1]), .reg_addr_i(addr),
    .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .irq_o(irq),
    .drive_one_o(drv1), .drive_two_o(drv2), .phase_one_clock_o(phase_one_clock), .phase_two_clock_o(phase_two_clock),
    .sync_o(sync), .discharge_hold_o(dhold), .ovp_to_ton_o(ovp_ton), .startup_flag_o(startup_flag),
    .stage_ready_out_o(ready), .phase_sel_o(sel));
  ipm_gate_model PARTNER (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .drive_i({drv2, drv1}),
    .stage_ready_i(ready), .hold_demag_i(hold_dem), .demag_o(demag), .ton_end_o(ton_end),
    .conv_run_o(conv_run));
  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic close_out();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  function automatic logic sig(input int s);
    case (s)
      0: return sync;
      1: return phase_one_clock;
      2: return phase_two_clock;
      3: return drv1 | drv2;
      4: return ready;
      5: return startup_flag;
      default: return irq;
    endcase
  endfunction
  // Bounded wait; returns just after the edge where the level is seen
  task automatic wait_lvl(input int s, input logic v);
    int i;
    for (i = 0; i < 300; i++) begin
      @(posedge clk_sys_i);
      #1;
      if (sig(s) === v) break;
    end
    if (i == 300) begin
      num_errors++;
      $display("[FAIL] wait %0d expected %b seen timeout", s, v);
      close_out();
    end
  endtask
  task automatic reg_wr(input logic [1:0] a, input logic [3:0] d);
    @(posedge clk_sys_i);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_sys_i);
    wr <= 1'b0;
  endtask
  task automatic reg_rd(input logic [1:0] a, output logic [3:0] d);
    @(posedge clk_sys_i);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_sys_i);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask
  task automatic osc_up(input ipm_phase_t ph);
    @(posedge clk_sys_i);
    ramp_hi <= 1'b1;
    wait_lvl(0, 1'b1);
    chk("sync", sync, 1'b1);
    chk("phase_sel", sel, ph);
    @(posedge clk_sys_i);
    ramp_hi <= 1'b0;
  endtask
  // Ramp below low threshold; the clock of the selected phase must follow
  task automatic osc_dn(input ipm_phase_t ph, input bit stall);
    @(posedge clk_sys_i);
    ramp_lo <= 1'b1;
    wait_lvl(0, 1'b0);
    wait_lvl(ph == IPM_PH_ONE ? 1 : 2, 1'b1);
    chk("idle_clock", ph == IPM_PH_ONE ? phase_two_clock : phase_one_clock, 1'b0);
    if (!stall) begin
      wait_lvl(3, 1'b1);
      wait_lvl(ph == IPM_PH_ONE ? 1 : 2, 1'b0);
      @(posedge clk_sys_i);
      ramp_lo <= 1'b0;
      wait_lvl(3, 1'b0);
    end
  endtask
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_reset();
    chk("drives", {drv2, drv1}, 2'h0);
    chk("clocks", {phase_two_clock, phase_one_clock}, 2'h0);
    chk("phase_reset", sel, IPM_PH_TWO);
    chk("startup", startup_flag, 1'b1);
    chk("ready_off", ready, 1'b0);
  endtask
  task automatic t_ready();
    @(posedge clk_sys_i);
    on <= 1'b1;
    repeat (8) @(posedge clk_sys_i);
    #1;
    chk("ready_startup", ready, 1'b0);
    @(posedge clk_sys_i);
    ea_chg <= 1'b0;
    wait_lvl(5, 1'b0);
    wait_lvl(4, 1'b1);
    chk("converter_run", conv_run, 1'b1);
    @(posedge clk_sys_i);
    fault <= 1'b1;
    wait_lvl(4, 1'b0);
    chk("ready_fault", ready, 1'b0);
    @(posedge clk_sys_i);
    fault <= 1'b0;
    wait_lvl(4, 1'b1);
    @(posedge clk_sys_i);
    on <= 1'b0;
    wait_lvl(5, 1'b1);
    chk("ready_down", ready, 1'b0);
    @(posedge clk_sys_i);
    on <= 1'b1;
    ea_chg <= 1'b1;
    repeat (8) @(posedge clk_sys_i);
    #1;
    chk("startup_set", startup_flag, 1'b1);
    @(posedge clk_sys_i);
    ea_chg <= 1'b0;
    wait_lvl(4, 1'b1);
  endtask
  task automatic t_phase();
    // First pulse starts from the watchdog then phases alternate
    for (int k = 0; k < 3; k++) begin
      osc_up(k == 1 ? IPM_PH_TWO : IPM_PH_ONE);
      osc_dn(k == 1 ? IPM_PH_TWO : IPM_PH_ONE, 1'b0);
    end
  endtask
  task automatic t_ccm();
    @(posedge clk_sys_i);
    hold_dem <= 1'b1;
    osc_up(IPM_PH_TWO);
    osc_dn(IPM_PH_TWO, 1'b1);
    repeat (10) @(posedge clk_sys_i);
    #1;
    chk("drive_ccm", drv2, 1'b0);
    chk("clock_held", phase_two_clock, 1'b1);
    chk("discharge_hold", dhold, 1'b1);
    @(posedge clk_sys_i);
    hold_dem <= 1'b0;
    wait_lvl(3, 1'b1);
    chk("drive_after_demag", drv2, 1'b1);
    wait_lvl(2, 1'b0);
    @(posedge clk_sys_i);
    ramp_lo <= 1'b0;
    wait_lvl(3, 1'b0);
    chk("discharge_end", dhold, 1'b0);
  endtask
  task automatic t_block(input bit inr, input ipm_phase_t ph);
    @(posedge clk_sys_i);
    ovp <= !inr;
    inrush <= inr;
    osc_up(ph);
    osc_dn(ph, 1'b1);
    @(posedge clk_sys_i);
    ramp_lo <= 1'b0;
    repeat (10) @(posedge clk_sys_i);
    #1;
    chk("ovp_flag", ovp_ton, !inr);
    chk("drives_blocked", {drv2, drv1}, 2'h0);
    @(posedge clk_sys_i);
    ovp <= 1'b0;
    inrush <= 1'b0;
    wait_lvl(3, 1'b1);
    chk("ovp_flag_off", ovp_ton, 1'b0);
    wait_lvl(3, 1'b0);
  endtask
  task automatic t_regs();
    logic [3:0] d;
    // Events left standing by the earlier scenarios
    reg_rd(2'h0, d);
    chk("status_ovp", d[`IPM_INT_OVP], 1'b1);
    chk("status_fault", d[`IPM_INT_FAULT], 1'b1);
    chk("status_ready", d[`IPM_INT_READY], 1'b1);
    reg_wr(2'h1, 4'h0);
    reg_wr(2'h0, 4'hf);
    osc_up(IPM_PH_ONE);
    osc_dn(IPM_PH_ONE, 1'b0);
    reg_rd(2'h0, d);
    chk("status_sync", d[0], 1'b1);
    chk("irq_masked", irq, 1'b0);
    reg_wr(2'h1, 4'h1);
    wait_lvl(6, 1'b1);
    reg_wr(2'h0, 4'h1);
    wait_lvl(6, 1'b0);
    reg_rd(2'h0, d);
    chk("status_clear", d[0], 1'b0);
    reg_wr(2'h3, 4'hf);
    reg_rd(2'h2, d);
    chk("unmapped", d, 4'h0);
    reg_rd(2'h1, d);
    chk("mask", d, 4'h1);
  endtask
  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (10) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    @(posedge clk_sys_i);
    #1;
    t_reset();
    t_ready();
    t_phase();
    t_ccm();
    t_block(1'b0, IPM_PH_ONE);
    t_block(1'b1, IPM_PH_TWO);
    t_regs();
    close_out();
  end
endmodule
